// ===== hw/sba_pkg.sv
/*
  Constants for the secondary bus two-tier arbiter: register indices, field positions,
  reset values and the time-out count.
  Assumes one 125 MHz clock that is also the secondary bus clock, and a reset that already
  merges every reset source of the device.
*/
// Summary of operation
// - Park bit picks bridge or last master.
// - Bridge tier bit places bridge, default high.
// - Per-master tier bits, default lower tier.
// - All arbiter fields return to defaults on reset.
// - Request mask register at index DDh, reset 00h.
// - Mask register holds automatic time-out masking control.
// - Two tiers, rotating, lower tier one slot in the higher rotation.
// - Optional time-out after 16 idle clocks.
// - Masked requests are ignored by arbitration.
package sba_pkg;
  localparam int NUM_MASTERS = 6;
  localparam int IDX_W = 3;
  localparam logic [IDX_W-1:0] BRIDGE_ID = 3'h6;
  localparam logic [IDX_W-1:0] LOW_SLOT = 3'h7;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_PRIO = 8'hDC;
  localparam logic [7:0] IDX_MASK = 8'hDD;
  localparam logic [7:0] IDX_TO_STAT = 8'hDE;
  localparam logic [7:0] IDX_IRQ_EN = 8'hDF;
  localparam logic [7:0] PRIO_RESET = 8'h40;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [5:0] STAT_RESET = 6'h00;
  localparam logic [5:0] IRQ_EN_RESET = 6'h00;
  localparam int PARK_BIT = 7;
  localparam int BRIDGE_TIER_BIT = 6;
  localparam int TO_EN_BIT = 7;
  localparam int AUTO_MASK_BIT = 6;
  // Time-out figure is given in bus clocks, so it is already a cycle count.
  localparam int TIMEOUT_CLKS = 16;
  localparam logic [4:0] TIMEOUT_LAST = 5'(TIMEOUT_CLKS - 1);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_BUSY} sba_state_e;
endpackage

// ===== hw/sba_pick_if.sv
/*
  Request vector, rotation pointer and chosen index between the arbiter and a rotating picker.
  Assumes both ends run on the arbiter clock.
*/
interface sba_pick_if import sba_pkg::*; #(parameter int N = 8);
  logic [N-1:0] req;
  logic [IDX_W-1:0] ptr;
  logic valid;
  logic [IDX_W-1:0] idx;
  modport arb (output req, output ptr, input valid, input idx);
  modport pick (input req, input ptr, output valid, output idx);
endinterface

// ===== hw/sba_rr_pick.sv
/*
  Rotating picker: the first request after the pointer wins.
  Assumes N matches the interface instance it is connected to.
*/
module sba_rr_pick import sba_pkg::*; #(
  parameter int N = 8
) (
  sba_pick_if.pick p
);
  always_comb begin
    int j;
    logic found;
    j = 0;
    found = 1'b0;
    p.valid = 1'b0;
    p.idx = '0;
    for (int k = 1; k <= N; k++) begin
      j = (int'(p.ptr) + k) % N;
      if (!found && p.req[j]) begin
        found = 1'b1;
        p.valid = 1'b1;
        p.idx = IDX_W'(j);
      end
    end
  end
endmodule

// ===== hw/sba_arbiter.sv
/*
  Secondary bus arbiter for six external masters and the bridge, with an APB register slave,
  two-tier rotation, parking, request masking, time-out and one interrupt.
  Assumes clk is the secondary bus clock and rst merges link, global and power-on reset.
*/
module sba_arbiter import sba_pkg::*; #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Secondary bus pins
  input wire logic [NUM_MASTERS-1:0] req_n,
  input wire logic frame_n,
  input wire logic irdy_n,
  output logic [NUM_MASTERS-1:0] gnt_n,
  // Bridge master
  input wire logic br_req,
  output logic br_gnt,
  // Interrupt
  output logic irq
);
  logic [NUM_MASTERS-1:0] req_s1, req_s2;
  logic frame_s1, frame_s2, irdy_s1, irdy_s2;
  logic [7:0] prio, next_prio, mask, next_mask;
  logic [5:0] stat, next_stat, irq_en, next_irq_en;
  logic next_irq;
  logic [31:0] next_prdata;
  sba_state_e state, next_state;
  logic [IDX_W-1:0] owner, next_owner, last, next_last, win;
  logic [IDX_W-1:0] hi_ptr, next_hi_ptr, lo_ptr, next_lo_ptr;
  logic own_low, next_own_low, win_low;
  logic [4:0] cnt, next_cnt;
  logic [NUM_MASTERS-1:0] next_gnt_n, to_evt;
  logic next_br_gnt, bus_idle;
  logic [6:0] all_req, tier, hi_req, lo_req;
  logic [7:0] reg_idx;
  logic in_page, hit, wr;
  sba_pick_if #(.N(8)) hi_if();
  sba_pick_if #(.N(7)) lo_if();

  // Pins come from other masters' logic, so each passes two flip-flops first.
  always_ff @(posedge clk) begin
    if (rst) begin
      req_s1 <= '1;
      req_s2 <= '1;
      frame_s1 <= 1'b1;
      frame_s2 <= 1'b1;
      irdy_s1 <= 1'b1;
      irdy_s2 <= 1'b1;
    end else begin
      req_s1 <= req_n;
      req_s2 <= req_s1;
      frame_s1 <= frame_n;
      frame_s2 <= frame_s1;
      irdy_s1 <= irdy_n;
      irdy_s2 <= irdy_s1;
    end
  end

  assign bus_idle = frame_s2 && irdy_s2;
  assign all_req = {br_req, ~req_s2 & ~mask[5:0]};
  assign tier = {prio[BRIDGE_TIER_BIT], prio[5:0]};
  assign hi_req = all_req & tier;
  assign lo_req = all_req & ~tier;

  assign hi_if.req = {|lo_req, hi_req};
  assign hi_if.ptr = hi_ptr;
  assign lo_if.req = lo_req;
  assign lo_if.ptr = lo_ptr;

  sba_rr_pick #(.N(8)) u_hi_pick (.p(hi_if.pick));
  sba_rr_pick #(.N(7)) u_lo_pick (.p(lo_if.pick));

  always_comb begin
    win_low = (hi_if.idx == LOW_SLOT);
    win = win_low ? lo_if.idx : hi_if.idx;
  end

  always_comb begin
    next_state = state;
    next_owner = owner;
    next_own_low = own_low;
    next_last = last;
    next_hi_ptr = hi_ptr;
    next_lo_ptr = lo_ptr;
    next_cnt = cnt;
    to_evt = '0;
    case (state)
      ST_IDLE: begin
        if (!bus_idle) begin
          next_state = ST_BUSY;
        end else if (hi_if.valid) begin
          next_state = ST_WAIT;
          next_owner = win;
          next_own_low = win_low;
          next_cnt = '0;
        end else begin
          next_owner = prio[PARK_BIT] ? BRIDGE_ID : last;
        end
      end
      ST_WAIT: begin
        if (!frame_s2) begin
          next_state = ST_BUSY;
          next_last = owner;
          if (own_low) begin
            next_hi_ptr = LOW_SLOT;
            next_lo_ptr = owner;
          end else begin
            next_hi_ptr = owner;
          end
        end else if (!all_req[owner]) begin
          next_state = ST_IDLE;
          next_owner = prio[PARK_BIT] ? BRIDGE_ID : last;
        end else if (mask[TO_EN_BIT] && cnt == TIMEOUT_LAST && owner != BRIDGE_ID) begin
          to_evt[owner] = 1'b1;
          next_state = ST_IDLE;
          next_owner = prio[PARK_BIT] ? BRIDGE_ID : last;
        end else begin
          next_cnt = cnt + 5'h01;
        end
      end
      ST_BUSY: begin
        if (bus_idle) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    for (int i = 0; i < NUM_MASTERS; i++) begin
      next_gnt_n[i] = (next_owner != IDX_W'(i));
    end
    next_br_gnt = (next_owner == BRIDGE_ID);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      owner <= BRIDGE_ID;
      own_low <= 1'b0;
      last <= BRIDGE_ID;
      hi_ptr <= LOW_SLOT;
      lo_ptr <= BRIDGE_ID;
      cnt <= '0;
      gnt_n <= '1;
      br_gnt <= 1'b1;
    end else begin
      state <= next_state;
      owner <= next_owner;
      own_low <= next_own_low;
      last <= next_last;
      hi_ptr <= next_hi_ptr;
      lo_ptr <= next_lo_ptr;
      cnt <= next_cnt;
      gnt_n <= next_gnt_n;
      br_gnt <= next_br_gnt;
    end
  end

  // Register slave: zero wait states, read data captured in the setup phase.
  assign reg_idx = paddr[9:2];
  assign in_page = (paddr[ADDR_W-1:10] == '0) && (paddr[1:0] == 2'h0);
  assign hit = in_page && (reg_idx == IDX_PRIO || reg_idx == IDX_MASK ||
                           reg_idx == IDX_TO_STAT || reg_idx == IDX_IRQ_EN);
  assign wr = psel && penable && pwrite && hit;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  always_comb begin
    next_prio = prio;
    next_mask = mask;
    next_stat = stat;
    next_irq_en = irq_en;
    next_prdata = prdata;
    if (wr && reg_idx == IDX_PRIO) begin
      next_prio = pwdata[7:0];
    end
    if (wr && reg_idx == IDX_MASK) begin
      next_mask = pwdata[7:0];
    end
    if (wr && reg_idx == IDX_IRQ_EN) begin
      next_irq_en = pwdata[5:0];
    end
    if (wr && reg_idx == IDX_TO_STAT) begin
      next_stat = stat & ~pwdata[5:0];
    end
    // A time-out in the same cycle as a clearing write still leaves its bit set.
    next_stat = next_stat | to_evt;
    if (mask[AUTO_MASK_BIT]) begin
      next_mask[5:0] = next_mask[5:0] | to_evt;
    end
    if (psel && !penable) begin
      case (reg_idx)
        IDX_PRIO: next_prdata = {24'h000000, prio};
        IDX_MASK: next_prdata = {24'h000000, mask};
        IDX_TO_STAT: next_prdata = {26'h0000000, stat};
        IDX_IRQ_EN: next_prdata = {26'h0000000, irq_en};
        default: next_prdata = 32'h00000000;
      endcase
      if (!in_page) begin
        next_prdata = 32'h00000000;
      end
    end
    next_irq = |(next_stat & next_irq_en);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prio <= PRIO_RESET;
      mask <= MASK_RESET;
      stat <= STAT_RESET;
      irq_en <= IRQ_EN_RESET;
      prdata <= 32'h00000000;
      irq <= 1'b0;
    end else begin
      prio <= next_prio;
      mask <= next_mask;
      stat <= next_stat;
      irq_en <= next_irq_en;
      prdata <= next_prdata;
      irq <= next_irq;
    end
  end

  // Checks; the helpers below are read only by them.
  logic [6:0] hi_req_q;
  logic [4:0] wait_len;
  always_ff @(posedge clk) begin
    if (rst) begin
      hi_req_q <= '0;
      wait_len <= '0;
    end else begin
      hi_req_q <= hi_req;
      wait_len <= (state == ST_WAIT) ? wait_len + 5'h01 : 5'h00;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_open_grant;
    state == ST_WAIT && frame_s2 && all_req[owner] && owner != BRIDGE_ID;
  endsequence
  // The grant has already moved to the park target here, so the status bit is that of the previous owner.
  sequence s_timed_out;
    state == ST_IDLE && stat[$past(owner)] == 1'b1;
  endsequence

  a_park_bridge: assert property ((state == ST_IDLE && bus_idle && !hi_if.valid && prio[PARK_BIT])
    |=> (br_gnt && gnt_n == 6'h3F)) else $error("idle bus not parked on bridge");
  a_park_last: assert property ((state == ST_IDLE && bus_idle && !hi_if.valid && !prio[PARK_BIT])
    |=> (owner == $past(last))) else $error("idle bus not parked on last master");
  // Right after the bridge was served, the lower tier slot is next in the rotation and rightly wins.
  a_bridge_tier: assert property ((state == ST_IDLE && bus_idle && hi_req == 7'h40 && lo_req != 7'h00)
    |=> (($past(hi_ptr) == BRIDGE_ID) ? own_low : (owner == BRIDGE_ID && br_gnt)))
    else $error("high tier bridge lost to lower tier");
  a_master_tier: assert property ((state == ST_IDLE && bus_idle && hi_req != 7'h00 && lo_req == 7'h00)
    |=> (state == ST_WAIT && hi_req_q[owner])) else $error("grant left the higher tier");
  a_reset_value: assert property ($fell(rst) |-> (prio == PRIO_RESET && mask == MASK_RESET))
    else $error("arbiter registers not at defaults after reset");
  a_mask_write: assert property ((wr && reg_idx == IDX_MASK && to_evt == 6'h00)
    |=> (mask == $past(pwdata[7:0]))) else $error("mask write not stored");
  a_auto_mask: assert property ((to_evt != 6'h00 && mask[AUTO_MASK_BIT])
    |=> ((mask[5:0] & $past(to_evt)) == $past(to_evt))) else $error("timed out request not masked");
  a_tier_order: assert property ((state == ST_IDLE && bus_idle && hi_if.valid && hi_if.idx != LOW_SLOT)
    |=> (!own_low && gnt_n != 6'h3F || br_gnt)) else $error("lower tier served before higher");
  a_timeout_len: assert property ((to_evt != 6'h00) |-> (wait_len == TIMEOUT_LAST && mask[TO_EN_BIT]))
    else $error("time-out not at sixteen clocks");
  a_timeout_flag: assert property ((s_open_grant ##0 (cnt == TIMEOUT_LAST && mask[TO_EN_BIT]))
    |=> s_timed_out ##1 (state != ST_WAIT || stat != 6'h00)) else $error("time-out status missing");
  a_no_timeout: assert property (!mask[TO_EN_BIT] |-> to_evt == 6'h00)
    else $error("time-out while disabled");
  a_masked_req: assert property ((state == ST_IDLE && next_state == ST_WAIT && next_owner != BRIDGE_ID)
    |-> !mask[next_owner]) else $error("masked request granted");
  a_low_slot: assert property ((state == ST_IDLE && bus_idle && hi_if.valid && hi_if.idx == LOW_SLOT)
    |=> (own_low && state == ST_WAIT)) else $error("lower tier slot skipped");
endmodule

// ===== sim/sba_masters_model.sv
/*
  Behavioural model of the external masters on the secondary bus.
  Assumes the bus clock is the arbiter clock and frame_n and irdy_n rest high through pull-ups.
*/
module sba_masters_model import sba_pkg::*; (
  // Clock
  input wire logic clk,
  // Bench control
  input wire logic [NUM_MASTERS-1:0] want,
  input wire logic respond,
  // Bus pins
  input wire logic [NUM_MASTERS-1:0] gnt_n,
  output logic [NUM_MASTERS-1:0] req_n,
  output logic frame_n,
  output logic irdy_n,
  // Observation
  output logic started,
  output int who
);
  timeunit 1ns;
  timeprecision 1ps;
  int busy = 0;
  int gap = 0;
  assign req_n = ~want;
  initial begin
    frame_n = 1'b1;
    irdy_n = 1'b1;
    started = 1'b0;
    who = 0;
  end
  // The gap after a transaction lets a stale grant move on before anyone starts again.
  always @(posedge clk) begin
    started <= 1'b0;
    if (busy != 0) begin
      busy <= busy - 1;
      if (busy == 1) begin
        frame_n <= 1'b1;
        irdy_n <= 1'b1;
      end
    end else if (gap != 0) begin
      gap <= gap - 1;
    end else if (respond && (~gnt_n & want) != '0) begin
      frame_n <= 1'b0;
      irdy_n <= 1'b0;
      busy <= 3;
      gap <= 8;
      started <= 1'b1;
      for (int k = NUM_MASTERS - 1; k >= 0; k--)
        if (!gnt_n[k] && want[k]) who <= k;
    end
  end
endmodule

// ===== sim/tb_sba_arbiter.sv
/*
  Self-checking bench for the secondary bus arbiter: registers, rotation, parking, masking,
  time-out and interrupt.
  Assumes the master model on the bus pins and zero-wait APB answers.
*/
module tb_sba_arbiter import sba_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic br_req = 1'b0;
  logic [5:0] want = '0;
  logic respond = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, frame_n, irdy_n, br_gnt, irq, started, err;
  logic [NUM_MASTERS-1:0] req_n, gnt_n;
  logic [31:0] rd;
  int who;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  sba_arbiter uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_n(req_n), .frame_n(frame_n),
    .irdy_n(irdy_n), .gnt_n(gnt_n), .br_req(br_req), .br_gnt(br_gnt), .irq(irq));
  sba_masters_model masters (.clk(clk), .want(want), .respond(respond), .gnt_n(gnt_n), .req_n(req_n),
    .frame_n(frame_n), .irdy_n(irdy_n), .started(started), .who(who));
  initial begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors = errors + 1;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    logic rdy;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= 12'({idx, 2'b00});
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // The request stands until pready is seen high at a rising edge, and the answer is taken there.
    do begin
      @(posedge clk);
      rdy = pready;
      err = pslverr;
      rd = prdata;
    end while (rdy !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, '0);
    chk(rd, exp);
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic do_reset(input int n);
    @(posedge clk);
    rst <= 1'b1;
    repeat (n) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic wait_start(output int m);
    int t;
    t = 0;
    do begin
      @(negedge clk);
      t++;
    end while (started !== 1'b1 && t < 200);
    m = (t < 200) ? who : -1;
  endtask
  task automatic t_regs();
    rdchk(IDX_PRIO, 32'h40);
    rdchk(IDX_MASK, 32'h00);
    rdchk(IDX_TO_STAT, 32'h00);
    rdchk(IDX_IRQ_EN, 32'h00);
    chk(32'({gnt_n, br_gnt}), 32'h7F);
    apb(1'b1, IDX_PRIO, 32'hBF);
    apb(1'b1, IDX_MASK, 32'hFF);
    rdchk(IDX_MASK, 32'hFF);
    rdchk(8'h10, 32'h00);
    chk(32'(err), 32'h1);
    do_reset(3);
    rdchk(IDX_PRIO, 32'h40);
    rdchk(IDX_MASK, 32'h00);
    $display("t_regs finished");
  endtask
  task automatic t_tier();
    logic [7:0] p [2] = '{8'h40, 8'h01};
    for (int i = 0; i < 2; i++) begin
      do_reset(3);
      apb(1'b1, IDX_PRIO, 32'(p[i]));
      // The bridge asks two edges late, so both requests meet in one arbitration after the synchroniser.
      @(posedge clk);
      want <= 6'h01;
      repeat (2) @(posedge clk);
      br_req <= 1'b1;
      wt(10);
      chk(32'({gnt_n, br_gnt}), (i == 0) ? 32'h7F : 32'h7C);
      @(posedge clk);
      br_req <= 1'b0;
      want <= 6'h00;
    end
    $display("t_tier finished");
  endtask
  task automatic t_rot_park();
    int exp_m [6] = '{0, 1, 2, 0, 1, 3};
    int m;
    do_reset(3);
    apb(1'b1, IDX_PRIO, 32'h43);
    @(posedge clk);
    want <= 6'h0F;
    respond <= 1'b1;
    foreach (exp_m[i]) begin
      wait_start(m);
      chk(32'(m), 32'(exp_m[i]));
    end
    @(posedge clk);
    want <= 6'h00;
    wt(16);
    chk(32'({gnt_n, br_gnt}), 32'h6E);
    apb(1'b1, IDX_PRIO, 32'hC3);
    wt(6);
    chk(32'({gnt_n, br_gnt}), 32'h7F);
    $display("t_rot_park finished");
  endtask
  task automatic t_mask();
    apb(1'b1, IDX_MASK, 32'h01);
    @(posedge clk);
    respond <= 1'b0;
    want <= 6'h01;
    wt(20);
    chk(32'({gnt_n, br_gnt}), 32'h7F);
    apb(1'b1, IDX_MASK, 32'h00);
    wt(6);
    chk(32'({gnt_n, br_gnt}), 32'h7C);
    @(posedge clk);
    want <= 6'h00;
    $display("t_mask finished");
  endtask
  task automatic t_timeout();
    int n;
    apb(1'b1, IDX_IRQ_EN, 32'h08);
    @(posedge clk);
    want <= 6'h08;
    wt(40);
    chk(32'({gnt_n, br_gnt}), 32'h6E);
    rdchk(IDX_TO_STAT, 32'h00);
    @(posedge clk);
    want <= 6'h00;
    wt(8);
    apb(1'b1, IDX_MASK, 32'hC0);
    @(posedge clk);
    want <= 6'h08;
    n = 0;
    while (gnt_n[3] !== 1'b0 && n < 50) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (gnt_n[3] === 1'b0 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk(32'(n), 32'(TIMEOUT_CLKS));
    wt(2);
    chk(32'(irq), 32'h1);
    rdchk(IDX_TO_STAT, 32'h08);
    rdchk(IDX_MASK, 32'hC8);
    apb(1'b1, IDX_IRQ_EN, 32'h00);
    wt(2);
    chk(32'(irq), 32'h0);
    apb(1'b1, IDX_IRQ_EN, 32'h08);
    wt(2);
    chk(32'(irq), 32'h1);
    apb(1'b1, IDX_TO_STAT, 32'h08);
    wt(2);
    chk(32'(irq), 32'h0);
    rdchk(IDX_TO_STAT, 32'h00);
    @(posedge clk);
    want <= 6'h00;
    $display("t_timeout finished");
  endtask
  initial begin
    do_reset(12);
    t_regs();
    t_tier();
    t_rot_park();
    t_mask();
    t_timeout();
    end_of_test();
  end
endmodule
